// ### logic/serial_host_port_defines.vh
/*
 Constants of the serial host port and the capture port.
 Assumes one 200 MHz system clock; included by its bare name.
*/
`ifndef SERIAL_HOST_PORT_DEFINES_VH
`define SERIAL_HOST_PORT_DEFINES_VH

// System clock and capture clock rates in MHz; capture bit periods in clk_sys_in cycles, gap in capture bit periods
`define CLK_SYS_MHZ       200
`define CAP_FAST_MHZ      8
`define CAP_SLOW_MHZ      4
`define CAP_PER_FAST      (`CLK_SYS_MHZ / `CAP_FAST_MHZ)
`define CAP_PER_SLOW      (`CLK_SYS_MHZ / `CAP_SLOW_MHZ)
`define CAP_GAP_CYCLES    3'h7

// Serial frame layout
`define HDR_BITS          6'h18
`define WORD_BITS         6'h20

// Register addresses
`define ADDR_HARM_BASE    16'hE880
`define ADDR_CONFIG       16'hE618
`define ADDR_CAP_CFG      16'hE706

// Field positions
`define CFG_CAP_EN        6
`define CAP_CLK_SEL       0
`define CAP_PKG8          1
`define CAP_GAP_EN        2
`define CAP_SET_LO        3
`define CAP_SET_HI        4
`define CAP_SEL_POL       5

// Reset values
`define CONFIG_RST        8'h00
`define CAP_CFG_RST       6'h00

// Word counts per word set
`define SET_ALL_WORDS     5'h10
`define SET_WAVE_WORDS    5'h07
`define SET_POWER_WORDS   5'h09

`endif

// ### logic/serial_host_port_and_capture.v
/*
 Serial host port (slave) and high speed capture port (master),
 sharing the data-out and chip-select pins.
 Assumes pins are asynchronous to clk_sys_in, register storage answers
 reg_rdata_in one cycle after reg_rd_out, and wave words are stable
 from sample_update_in until the capture burst ends.
*/
`include "serial_host_port_defines.vh"

module serial_host_port_and_capture
(
    // Clock and reset
    input  wire         clk_sys_in,
    input  wire         nrst_in,
    // Host link pins
    input  wire         sclk_in,
    input  wire         mosi_in,
    input  wire         chip_select_shared_pin_in,
    output reg          chip_select_shared_pin_out,
    output reg          chip_select_shared_pin_oe_out,
    output reg          slave_out_shared_pin_out,
    output reg          slave_out_shared_pin_oe_out,
    output reg          capture_serial_clock_out,
    // Interface strap: high when configured for I2C
    input  wire         i2c_mode_in,
    // Register storage port
    output reg  [15:0]  reg_addr_out,
    output reg          reg_rd_out,
    input  wire [31:0]  reg_rdata_in,
    output reg          reg_wr_out,
    output reg  [31:0]  reg_wdata_out,
    output reg  [5:0]   reg_wbits_out,
    // Waveform and power words
    input  wire         sample_update_in,
    input  wire [383:0] wave_words_in,
    // Status
    output reg          capture_busy_out
);

    localparam C_IDLE = 3'b001;
    localparam C_SEND = 3'b010;
    localparam C_GAP  = 3'b100;

    // Two-flop synchronisers; third stage only for edge finding
    reg  [2:0]  sclk_sy;
    reg  [1:0]  mosi_sy;
    reg  [2:0]  cs_sy;
    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sclk_sy <= 3'h7;
            mosi_sy <= 2'h0;
            cs_sy   <= 3'h7;
        end
        else
        begin
            sclk_sy <= {sclk_sy[1:0], sclk_in};
            mosi_sy <= {mosi_sy[0], mosi_in};
            cs_sy   <= {cs_sy[1:0], chip_select_shared_pin_in};
        end
    end

    wire        spi_mode = ~i2c_mode_in;
    wire        ss_act   = ~cs_sy[1] & spi_mode;
    wire        ss_end   = cs_sy[1] & ~cs_sy[2];
    wire        sck_rise = sclk_sy[1] & ~sclk_sy[2];
    wire        sck_fall = ~sclk_sy[1] & sclk_sy[2];

    reg  [7:0]  config_reg;
    reg  [5:0]  capture_port_config;
    reg         hold_high;
    reg  [5:0]  hdr_cnt;
    reg  [22:0] hdr;
    reg         rd_mode;
    reg  [15:0] addr;
    reg  [31:0] shift;
    reg  [5:0]  dcnt;
    reg         need_load;
    reg         rd_d;
    reg  [31:0] rdata;
    reg  [31:0] rbuf;
    reg  [31:0] wdata;
    reg  [5:0]  wcnt;

    wire        cap_on = config_reg[`CFG_CAP_EN] & i2c_mode_in;

    // Internal registers answer from here, the rest from storage
    always @*
    begin
        if (addr == `ADDR_CONFIG)
            rdata = {24'h0, config_reg};
        else if (addr == `ADDR_CAP_CFG)
            rdata = {26'h0, capture_port_config};
        else
            rdata = reg_rdata_in;
    end

    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            config_reg          <= `CONFIG_RST;
            capture_port_config <= `CAP_CFG_RST;
            hdr_cnt             <= 6'h0;
            hdr                 <= 23'h0;
            rd_mode             <= 1'b0;
            addr                <= 16'h0;
            shift               <= 32'h0;
            dcnt                <= 6'h0;
            need_load           <= 1'b0;
            rd_d                <= 1'b0;
            rbuf                <= 32'h0;
            wdata               <= 32'h0;
            wcnt                <= 6'h0;
            reg_addr_out        <= 16'h0;
            reg_rd_out          <= 1'b0;
            reg_wr_out          <= 1'b0;
            reg_wdata_out       <= 32'h0;
            reg_wbits_out       <= 6'h0;
        end
        else
        begin
            reg_rd_out <= 1'b0;
            reg_wr_out <= 1'b0;
            rd_d       <= reg_rd_out;
            // Parked until the word boundary so the last bit still stands
            if (rd_d)
                rbuf <= rdata;
            if (!ss_act)
            begin
                if (ss_end && spi_mode && !rd_mode && hdr_cnt == `HDR_BITS &&
                    (wcnt == 6'h08 || wcnt == 6'h10 || wcnt == `WORD_BITS))
                begin
                    if (addr == `ADDR_CONFIG)
                        config_reg <= wdata[7:0];
                    else if (addr == `ADDR_CAP_CFG)
                        capture_port_config <= wdata[5:0];
                    else
                    begin
                        reg_wr_out    <= 1'b1;
                        reg_addr_out  <= addr;
                        reg_wdata_out <= wdata;
                        reg_wbits_out <= wcnt;
                    end
                end
                hdr_cnt   <= 6'h0;
                wcnt      <= 6'h0;
                // Short writes stay right aligned
                wdata     <= 32'h0;
                dcnt      <= 6'h0;
                need_load <= 1'b0;
            end
            else if (sck_rise)
            begin
                if (hdr_cnt != `HDR_BITS)
                begin
                    hdr     <= {hdr[21:0], mosi_sy[1]};
                    hdr_cnt <= hdr_cnt + 6'h1;
                    if (hdr_cnt == `HDR_BITS - 6'h1)
                    begin
                        addr    <= {hdr[14:0], mosi_sy[1]};
                        // only bit 0 of the command byte counts
                        rd_mode <= hdr[15];
                        if (hdr[15])
                        begin
                            reg_rd_out   <= 1'b1;
                            reg_addr_out <= {hdr[14:0], mosi_sy[1]};
                            need_load    <= 1'b1;
                        end
                    end
                end
                // value bits follow the address directly
                else if (!rd_mode && wcnt != `WORD_BITS)
                begin
                    wdata <= {wdata[30:0], mosi_sy[1]};
                    wcnt  <= wcnt + 6'h1;
                end
            end
            else if (sck_fall && rd_mode && hdr_cnt == `HDR_BITS)
            begin
                if (need_load)
                begin
                    // first data bit goes out at this falling edge
                    need_load <= 1'b0;
                    dcnt      <= 6'h1;
                    shift     <= rbuf;
                end
                else
                begin
                    shift <= {shift[30:0], 1'b0};
                    dcnt  <= dcnt + 6'h1;
                    if (dcnt == `WORD_BITS - 6'h1)
                    begin
                        addr         <= addr + 16'h1;
                        reg_addr_out <= addr + 16'h1;
                        reg_rd_out   <= 1'b1;
                        need_load    <= 1'b1;
                    end
                end
            end
        end
    end

    // Capture word selection in send order
    function [3:0] word_src;
        input [1:0] set;
        input [3:0] n;
        begin
            word_src = n;
            if (set == 2'h1 && n == 4'h6)
                word_src = 4'h7;
            else if (set == 2'h2)
            begin
                if (n == 4'h0)
                    word_src = 4'h6;
                else if (n < 4'h3)
                    word_src = n + 4'h7;
                else
                    word_src = n + 4'h7;
            end
        end
    endfunction

    wire [1:0]  wset    = capture_port_config[`CAP_SET_HI:`CAP_SET_LO];
    wire [4:0]  nwords  = (wset == 2'h1) ? `SET_WAVE_WORDS :
                          (wset == 2'h2) ? `SET_POWER_WORDS : `SET_ALL_WORDS;
    localparam [31:0] PER_FAST_W = `CAP_PER_FAST;
    localparam [31:0] PER_SLOW_W = `CAP_PER_SLOW;
    wire [5:0]  cper    = capture_port_config[`CAP_CLK_SEL] ?
                          PER_SLOW_W[5:0] : PER_FAST_W[5:0];
    wire        pol     = capture_port_config[`CAP_SEL_POL];

    reg  [2:0]  cstate;
    reg  [5:0]  ccnt;
    reg  [4:0]  bitn;
    reg  [3:0]  wordn;
    reg  [2:0]  gapn;
    reg  [31:0] cshift;
    reg  [3:0]  src;
    reg  [23:0] raw;

    always @*
    begin
        src = word_src(wset, wordn + 4'h1);
        raw = wave_words_in[src * 24 +: 24];
    end

    wire [23:0] first_raw = wave_words_in[word_src(wset, 4'h0) * 24 +: 24];
    wire        bit_end   = (ccnt == cper - 6'h1);
    wire        last_bit  = (bitn == 5'h1F);
    // package edge every 8 or 32 bits
    wire        pkg_end   = capture_port_config[`CAP_PKG8] ?
                            (bitn[2:0] == 3'h7) : last_bit;
    wire        last_word = ({1'b0, wordn} == nwords - 5'h1);

    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cstate <= C_IDLE;
            ccnt   <= 6'h0;
            bitn   <= 5'h0;
            wordn  <= 4'h0;
            gapn   <= 3'h0;
            cshift <= 32'h0;
        end
        else
        begin
            case (cstate)
            C_IDLE:
            begin
                // updates during a burst are skipped
                if (cap_on && sample_update_in)
                begin
                    cshift <= {{8{first_raw[23]}}, first_raw};
                    cstate <= C_SEND;
                    ccnt   <= 6'h0;
                    bitn   <= 5'h0;
                    wordn  <= 4'h0;
                end
            end
            C_SEND:
            begin
                ccnt <= ccnt + 6'h1;
                if (bit_end)
                begin
                    ccnt <= 6'h0;
                    bitn <= bitn + 5'h1;
                    cshift <= {cshift[30:0], 1'b0};
                    if (last_bit)
                    begin
                        wordn  <= wordn + 4'h1;
                        cshift <= {{8{raw[23]}}, raw};
                    end
                    if (last_bit && last_word)
                        cstate <= C_IDLE;
                    else if (pkg_end && capture_port_config[`CAP_GAP_EN])
                    begin
                        cstate <= C_GAP;
                        gapn   <= 3'h1;
                    end
                end
            end
            C_GAP:
            begin
                ccnt <= ccnt + 6'h1;
                if (bit_end)
                begin
                    ccnt <= 6'h0;
                    gapn <= gapn + 3'h1;
                    if (gapn == `CAP_GAP_CYCLES)
                        cstate <= C_SEND;
                end
            end
            default:
                cstate <= C_IDLE;
            endcase
            if (!cap_on)
                cstate <= C_IDLE;
        end
    end

    wire        half = (ccnt >= {1'b0, cper[5:1]});

    // Pin drivers, all registered
    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hold_high                     <= 1'b1;
            slave_out_shared_pin_out      <= 1'b1;
            slave_out_shared_pin_oe_out   <= 1'b1;
            chip_select_shared_pin_out    <= 1'b1;
            chip_select_shared_pin_oe_out <= 1'b1;
            capture_serial_clock_out      <= 1'b1;
            capture_busy_out              <= 1'b0;
        end
        else
        begin
            // Pins stay high until a host or capture takes them over
            if (ss_act || cap_on)
                hold_high <= 1'b0;
            capture_busy_out <= (cstate != C_IDLE);
            // data at falling edge, clock low first half
            capture_serial_clock_out <= ~(cstate == C_SEND) | half;
            if (cap_on)
            begin
                // capture port drives both shared pins
                // Data held through a gap; within a burst it moves only with a falling clock
                if (cstate == C_GAP)
                    slave_out_shared_pin_out  <= slave_out_shared_pin_out;
                else
                    slave_out_shared_pin_out  <= cshift[31] & (cstate != C_IDLE);
                slave_out_shared_pin_oe_out   <= 1'b1;
                chip_select_shared_pin_out    <= (cstate != C_IDLE) ? pol : ~pol;
                chip_select_shared_pin_oe_out <= 1'b1;
            end
            else if (hold_high && !ss_act)
            begin
                slave_out_shared_pin_out      <= 1'b1;
                slave_out_shared_pin_oe_out   <= 1'b1;
                chip_select_shared_pin_out    <= 1'b1;
                chip_select_shared_pin_oe_out <= 1'b1;
            end
            else
            begin
                // released outside a read data phase
                slave_out_shared_pin_out      <= shift[31];
                slave_out_shared_pin_oe_out   <= ss_act & rd_mode &
                                                 (hdr_cnt == `HDR_BITS) &
                                                 (dcnt != 6'h0);
                chip_select_shared_pin_out    <= 1'b1;
                chip_select_shared_pin_oe_out <= 1'b0;
            end
        end
    end

endmodule

// ### verif/shp_props.sv
/*
 Checker of host port and capture port pin timing.
 Bound to the design top; sees only its ports.
*/
module shp_props
(
    input wire       clk_sys_in,
    input wire       nrst_in,
    input wire       chip_select_shared_pin_in,
    input wire       chip_select_shared_pin_out,
    input wire       chip_select_shared_pin_oe_out,
    input wire       slave_out_shared_pin_out,
    input wire       slave_out_shared_pin_oe_out,
    input wire       capture_serial_clock_out,
    input wire       i2c_mode_in,
    input wire       reg_rd_out,
    input wire       reg_wr_out,
    input wire [5:0] reg_wbits_out,
    input wire       sample_update_in,
    input wire       capture_busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    chk_rst_pins_high:
    assert property ($rose(nrst_in) |-> chip_select_shared_pin_out
        && chip_select_shared_pin_oe_out && slave_out_shared_pin_out
        && slave_out_shared_pin_oe_out) else $error("shared pins not high after reset");
    chk_wr_size_legal:
    assert property (reg_wr_out |-> reg_wbits_out == 6'h08 || reg_wbits_out == 6'h10
        || reg_wbits_out == 6'h20) else $error("write of illegal size");
    chk_strobe_single:
    assert property (reg_rd_out || reg_wr_out |=> !reg_rd_out && !reg_wr_out)
        else $error("storage strobe longer than one cycle");
    chk_i2c_mutes_spi:
    assert property (i2c_mode_in [*8] |-> !reg_rd_out && !reg_wr_out)
        else $error("host port active in I2C mode");
    chk_cap_needs_i2c:
    assert property (!i2c_mode_in && !capture_busy_out |=> !capture_busy_out)
        else $error("capture started while host port in use");
    chk_burst_on_update:
    assert property ($rose(capture_busy_out) |-> $past(sample_update_in, 2))
        else $error("capture burst without sample update");
    chk_clk_idle_high:
    assert property (!capture_busy_out [*2] |-> capture_serial_clock_out)
        else $error("capture clock not idle high");
    chk_clk_low_phase:
    assert property ($fell(capture_serial_clock_out) |-> !capture_serial_clock_out [*8])
        else $error("capture clock low phase too short");
    chk_sel_held:
    assert property (capture_busy_out && $past(capture_busy_out)
        |-> $stable(chip_select_shared_pin_out) && chip_select_shared_pin_oe_out)
        else $error("capture select moved within a burst");
    chk_data_on_fall:
    assert property (capture_busy_out && $past(capture_busy_out)
        && !$fell(capture_serial_clock_out) |-> $stable(slave_out_shared_pin_out))
        else $error("capture data moved off a falling clock");
    chk_miso_release:
    assert property ($rose(chip_select_shared_pin_in) && !i2c_mode_in
        |-> ##[1:8] !slave_out_shared_pin_oe_out) else $error("data pin not released");
endmodule

bind serial_host_port_and_capture shp_props u_props
(
    .clk_sys_in, .nrst_in, .chip_select_shared_pin_in, .chip_select_shared_pin_out,
    .chip_select_shared_pin_oe_out, .slave_out_shared_pin_out,
    .slave_out_shared_pin_oe_out, .capture_serial_clock_out, .i2c_mode_in,
    .reg_rd_out, .reg_wr_out, .reg_wbits_out, .sample_update_in, .capture_busy_out
);

// ### verif/host_peer.sv
/*
 Host-side peer: SPI master on the host pins, receiver on the capture link.
 Assumes the bench resolves the shared pins and the capture select level.
*/
module host_peer
(
    input  wire  clk_sys_in,
    input  wire  miso_in,
    input  wire  cap_clk_in,
    input  wire  cap_act_in,
    output logic sclk_out,
    output logic mosi_out,
    output logic cs_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 16;
    logic rx[$];
    logic cap_q[$];
    logic clk_d = 1'b1;
    int   since = 0;
    int   t_min;
    int   t_max;
    int   n_long;

    initial
    begin
        sclk_out = 1'b1;
        mosi_out = 1'b0;
        cs_n_out = 1'b1;
    end

    // change on fall, MSB first, sample on rise
    task automatic xfer(input int nb, input logic [87:0] v);
        rx.delete();
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        repeat (HALF) @(posedge clk_sys_in);
        for (int i = nb - 1; i >= 0; i--)
        begin
            sclk_out <= 1'b0;
            mosi_out <= v[i];
            repeat (HALF) @(posedge clk_sys_in);
            sclk_out <= 1'b1;
            repeat (HALF) @(posedge clk_sys_in);
            rx.push_back(miso_in);
        end
        // select up at end of last cycle
        cs_n_out <= 1'b1;
        mosi_out <= ~v[0];
        repeat (4 * HALF) @(posedge clk_sys_in);
    endtask

    task automatic clear();
        cap_q.delete();
        t_min = 9999;
        t_max = 0;
        n_long = 0;
    endtask

    // data taken on rising capture clock
    always @(posedge clk_sys_in)
    begin
        clk_d <= cap_clk_in;
        since <= since + 1;
        if (cap_act_in && cap_clk_in && !clk_d)
        begin
            if (cap_q.size() > 0)
            begin
                t_min <= (since < t_min) ? since : t_min;
                t_max <= (since > t_max) ? since : t_max;
                n_long <= n_long + int'(since > 60);
            end
            cap_q.push_back(miso_in);
            since <= 1;
        end
    end
endmodule

// ### verif/tb_top.sv
/*
 Testbench of the serial host port and capture port.
 Host transfers go through the peer; the bench models register storage.
*/
`include "serial_host_port_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk_sys_in = 1'b0;
    logic         nrst_in = 1'b0;
    logic         i2c_mode_in = 1'b0;
    logic         sample_update_in = 1'b0;
    logic         tog = 1'b0;
    logic         pol = 1'b0;
    logic [31:0]  reg_rdata_in = 32'h0;
    logic [383:0] wave_words_in;
    wire          sclk, mosi, cs_n, cs_out, cs_oe, so_out, so_oe, cap_clk, busy;
    wire          reg_rd_out, reg_wr_out;
    wire  [15:0]  reg_addr_out;
    wire  [31:0]  reg_wdata_out;
    wire  [5:0]   reg_wbits_out;
    wire          cs_pin = i2c_mode_in ? (cs_oe ? cs_out : 1'b1) : cs_n;
    // Released line toggles so a stale level cannot pass
    wire          miso_pin = so_oe ? so_out : tog;
    int           n_fail = 0;
    int           tests_run = 0;
    int           wr_cnt = 0;
    int           nb;
    int           c0;
    logic [15:0]  wa;
    logic [31:0]  wd;
    logic [31:0]  wval;
    logic [5:0]   wb;
    logic [63:0]  got;

    always #2.5 clk_sys_in = ~clk_sys_in;

    serial_host_port_and_capture dut
    (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk), .mosi_in(mosi),
        .chip_select_shared_pin_in(cs_pin), .chip_select_shared_pin_out(cs_out),
        .chip_select_shared_pin_oe_out(cs_oe), .slave_out_shared_pin_out(so_out),
        .slave_out_shared_pin_oe_out(so_oe), .capture_serial_clock_out(cap_clk),
        .i2c_mode_in(i2c_mode_in), .reg_addr_out(reg_addr_out), .reg_rd_out(reg_rd_out),
        .reg_rdata_in(reg_rdata_in), .reg_wr_out(reg_wr_out),
        .reg_wdata_out(reg_wdata_out), .reg_wbits_out(reg_wbits_out),
        .sample_update_in(sample_update_in), .wave_words_in(wave_words_in),
        .capture_busy_out(busy)
    );

    host_peer peer
    (
        .clk_sys_in(clk_sys_in), .miso_in(miso_pin), .cap_clk_in(cap_clk),
        .cap_act_in(i2c_mode_in && cs_pin == pol), .sclk_out(sclk), .mosi_out(mosi),
        .cs_n_out(cs_n)
    );

    always @(posedge clk_sys_in)
    begin
        tog <= ~tog;
        if (reg_rd_out)
            reg_rdata_in <= {reg_addr_out, ~reg_addr_out};
        if (reg_wr_out)
        begin
            wr_cnt <= wr_cnt + 1;
            wa <= reg_addr_out;
            wd <= reg_wdata_out;
            wb <= reg_wbits_out;
        end
    end

    function automatic logic [23:0] wv(input int k);
        return k[0] ? {20'hF0000, k[3:0]} : {20'h01230, k[3:0]};
    endfunction

    function automatic int widx(input logic [1:0] set, input int n);
        if (set == 2'b01)
            return (n < 6) ? n : 7;
        if (set == 2'b10)
            return (n == 0) ? 6 : n + 7;
        return n;
    endfunction

    initial
        for (int k = 0; k < 16; k++)
            wave_words_in[k*24 +: 24] <= wv(k);

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr8(input logic [15:0] a, input logic [7:0] v);
        peer.xfer(32, {56'h0, 8'h00, a, v});
    endtask

    task automatic pulse();
        sample_update_in <= 1'b1;
        @(posedge clk_sys_in);
        sample_update_in <= 1'b0;
    endtask

    task automatic cap(input logic [7:0] cfg);
        int per;
        int nw;
        int np;
        int k;
        logic [23:0] x;
        logic [31:0] w;
        logic ok;
        per = cfg[0] ? 50 : 25;
        nw = (cfg[4:3] == 2'b01) ? 7 : (cfg[4:3] == 2'b10) ? 9 : 16;
        np = cfg[2] ? (cfg[1] ? 4 * nw : nw) : 1;
        wr8(`ADDR_CAP_CFG, cfg);
        wr8(`ADDR_CONFIG, 8'h40);
        pol = cfg[5];
        i2c_mode_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        peer.clear();
        pulse();
        repeat (200) @(posedge clk_sys_in);
        pulse();
        for (k = 0; k < 40000 && busy === 1'b1; k++)
            @(posedge clk_sys_in);
        repeat (4) @(posedge clk_sys_in);
        ok = peer.cap_q.size() == nw * 32;
        for (int n = 0; n < nw && ok; n++)
        begin
            x = wv(widx(cfg[4:3], n));
            w = {{8{x[23]}}, x};
            for (int b = 0; b < 32; b++)
                ok &= peer.cap_q[n*32 + b] === w[31-b];
        end
        chk(ok, "capture word stream");
        chk(peer.t_min == per, "capture clock rate");
        chk(peer.t_max == (cfg[2] ? 8 * per : per), "package gap length");
        chk(peer.n_long == np - 1, "package count");
        chk(cs_pin === ~cfg[5] && busy === 1'b0, "select idle level");
        i2c_mode_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        chk(cs_oe && cs_out && so_oe && so_out && cap_clk && !busy, "reset levels");
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        for (int s = 0; s < 3; s++)
        begin
            nb = 8 << s;
            wval = 32'h9C5A3E71 >> (32 - nb);
            c0 = wr_cnt;
            peer.xfer(24 + nb, ({64'h0, 8'hA2, 16'h0100 + 16'(s)} << nb) | 88'(wval));
            chk(wr_cnt == c0 + 1 && wa === 16'h0100 + 16'(s) && wd === wval
                && wb === 6'(nb), "register write");
        end
        peer.xfer(88, {64'h0, 8'h01, `ADDR_HARM_BASE} << 64);
        for (int i = 0; i < 64; i++)
            got = {got[62:0], peer.rx[24 + i]};
        chk(got === {`ADDR_HARM_BASE, ~`ADDR_HARM_BASE, `ADDR_HARM_BASE + 16'h1,
            ~(`ADDR_HARM_BASE + 16'h1)}, "burst read data");
        chk(so_oe === 1'b0, "data pin released");
        wr8(`ADDR_CONFIG, 8'h40);
        pulse();
        repeat (100) @(posedge clk_sys_in);
        chk(busy === 1'b0, "capture idle in host mode");
        cap(8'h00);
        cap(8'h08);
        cap(8'hDC);
        cap(8'h37);
        stop_test();
    end

    initial
    begin
        repeat (95000) @(posedge clk_sys_in);
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
